// file: sec_exc_ctrl.v
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.vh"

module sec_exc_ctrl #(
	parameter ADDR_W = 8
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADDR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire bus_priv_i,
	input wire bus_secure_i,
	input wire dbg_reset_req_i,
	input wire tick_event_i,
	input wire nmi_taken_i,
	input wire svc_taken_i,
	input wire tick_taken_i,
	input wire irq_pending_i,
	input wire [8:0] pending_num_i,
	input wire [8:0] active_num_i,
	input wire step_preempt_i,
	input wire exc_return_i,
	input wire fault_i,
	input wire big_endian_i,
	output reg nmi_pend_o,
	output reg svc_pend_o,
	output reg tick_pend_o,
	output reg tick_nonsecure_o,
	output reg secure_priority_boost_o,
	output reg fault_nmi_security_o,
	output reg [2:0] priority_group_o,
	output reg reset_request_o,
	output reg clear_active_o,
	output reg priority_mask_o,
	output reg return_to_thread_o,
	output reg escalate_hardfault_o,
	output reg fault_taken_o
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

// True when data bit n lies in a selected byte lane and is written as 1
function wr_one;
	input [3:0] sel;
	input [31:0] dat;
	input integer n;
	begin
		wr_one = sel[n / 8] & dat[n];
	end
endfunction

// True when the byte lane holding bit n is selected
function lane_on;
	input [3:0] sel;
	input integer n;
	begin
		lane_on = sel[n / 8];
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus decode

wire [ADDR_W-1:0] adr_word;
wire req;
wire wr_acc;
wire rd_acc;
wire hit_ctst;
wire hit_rctl;
wire hit_pmask;
wire key_ok;

assign adr_word = {wb_adr_i[ADDR_W-1:2], 2'b00};
assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr_acc = req & wb_we_i;
assign rd_acc = req & ~wb_we_i;
assign hit_ctst = (adr_word == `SEC_OFF_CTST);
assign hit_rctl = (adr_word == `SEC_OFF_RCTL);
assign hit_pmask = (adr_word == `SEC_OFF_PMASK);
assign key_ok = wb_sel_i[3] & wb_sel_i[2] &
	(wb_dat_i[`SEC_RCTL_KEY_MSB:`SEC_RCTL_KEY_LSB] == `SEC_RCTL_KEY);

wire ctst_wr;
wire rctl_wr;
wire pmask_wr;

assign ctst_wr = wr_acc & hit_ctst;
assign rctl_wr = wr_acc & hit_rctl & key_ok;
assign pmask_wr = wr_acc & hit_pmask & bus_priv_i;

////////////////////////////////////////////////////////////////////////////////
// Software set and clear strobes

wire nmi_set;
wire nmi_clr;
wire svc_set;
wire svc_clr;
wire tick_set;
wire tick_clr;

assign nmi_set = ctst_wr &
	wr_one(wb_sel_i, wb_dat_i, `SEC_CTST_NMI_SET);
assign nmi_clr = ctst_wr &
	wr_one(wb_sel_i, wb_dat_i, `SEC_CTST_NMI_CLR);
assign svc_set = ctst_wr &
	wr_one(wb_sel_i, wb_dat_i, `SEC_CTST_SVC_SET);
assign svc_clr = ctst_wr &
	wr_one(wb_sel_i, wb_dat_i, `SEC_CTST_SVC_CLR);
assign tick_set = ctst_wr &
	wr_one(wb_sel_i, wb_dat_i, `SEC_CTST_TICK_SET);
assign tick_clr = ctst_wr &
	wr_one(wb_sel_i, wb_dat_i, `SEC_CTST_TICK_CLR);

////////////////////////////////////////////////////////////////////////////////
// Pending flags, a set always wins over any clear in the same cycle

always @(posedge clk_i) begin
	if (rst_i) begin
		nmi_pend_o <= `SEC_PEND_RST;
		svc_pend_o <= `SEC_PEND_RST;
		tick_pend_o <= `SEC_PEND_RST;
	end else begin
		if (nmi_set)
			nmi_pend_o <= 1'b1;
		else if (nmi_clr | nmi_taken_i)
			nmi_pend_o <= 1'b0;
		if (svc_set)
			svc_pend_o <= 1'b1;
		else if (svc_clr | svc_taken_i)
			svc_pend_o <= 1'b0;
		if (tick_set | tick_event_i)
			tick_pend_o <= 1'b1;
		else if (tick_clr | tick_taken_i)
			tick_pend_o <= 1'b0;
	end
end

// Tick target state
always @(posedge clk_i) begin
	if (rst_i)
		tick_nonsecure_o <= `SEC_CTRL_RST;
	else if (ctst_wr & lane_on(wb_sel_i, `SEC_CTST_TICK_NS))
		tick_nonsecure_o <= wb_dat_i[`SEC_CTST_TICK_NS];
end

////////////////////////////////////////////////////////////////////////////////
// Return-to-base status and exception return

wire ret_base_nxt;
reg ret_base_r;

assign ret_base_nxt = (active_num_i != 9'h000) & ~irq_pending_i &
	(pending_num_i == 9'h000) & ~nmi_pend_o & ~svc_pend_o & ~tick_pend_o;

always @(posedge clk_i) begin
	if (rst_i)
		ret_base_r <= 1'b0;
	else
		ret_base_r <= ret_base_nxt;
end

always @(posedge clk_i) begin
	if (rst_i)
		return_to_thread_o <= 1'b0;
	else
		return_to_thread_o <= exc_return_i & ret_base_r;
end

////////////////////////////////////////////////////////////////////////////////
// Endianness strap, synchronised and caught once after reset release

reg endian_s1_r;
reg endian_s2_r;
reg [1:0] strap_cnt_r;
reg endian_r;

always @(posedge clk_i) begin
	if (rst_i) begin
		endian_s1_r <= 1'b0;
		endian_s2_r <= 1'b0;
	end else begin
		endian_s1_r <= big_endian_i;
		endian_s2_r <= endian_s1_r;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		strap_cnt_r <= 2'h0;
		endian_r <= 1'b0;
	end else if (strap_cnt_r != `SEC_STRAP_WAIT + 2'h1) begin
		strap_cnt_r <= strap_cnt_r + 2'h1;
		if (strap_cnt_r == `SEC_STRAP_WAIT)
			endian_r <= endian_s2_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Reset-control register

reg rst_sec_only_r;
wire sw_reset_ok;

// Non-secure software may not request reset while the secure-only bit is set
assign sw_reset_ok = bus_secure_i | ~rst_sec_only_r;

always @(posedge clk_i) begin
	if (rst_i) begin
		secure_priority_boost_o <= `SEC_CTRL_RST;
		fault_nmi_security_o <= `SEC_CTRL_RST;
		priority_group_o <= `SEC_GRP_RST;
		rst_sec_only_r <= `SEC_CTRL_RST;
	end else if (rctl_wr) begin
		if (lane_on(wb_sel_i, `SEC_RCTL_SBOOST))
			secure_priority_boost_o <= wb_dat_i[`SEC_RCTL_SBOOST];
		if (lane_on(wb_sel_i, `SEC_RCTL_FLT_NS))
			fault_nmi_security_o <= wb_dat_i[`SEC_RCTL_FLT_NS];
		if (lane_on(wb_sel_i, `SEC_RCTL_GRP_LSB))
			priority_group_o <=
				wb_dat_i[`SEC_RCTL_GRP_MSB:`SEC_RCTL_GRP_LSB];
		if (bus_secure_i & lane_on(wb_sel_i, `SEC_RCTL_RST_SEC))
			rst_sec_only_r <= wb_dat_i[`SEC_RCTL_RST_SEC];
	end
end

// System reset request holds until the system resets the block
always @(posedge clk_i) begin
	if (rst_i)
		reset_request_o <= 1'b0;
	else if (dbg_reset_req_i)
		reset_request_o <= 1'b1;
	else if (rctl_wr & sw_reset_ok &
		wr_one(wb_sel_i, wb_dat_i, `SEC_RCTL_RST_REQ))
		reset_request_o <= 1'b1;
end

// One-cycle pulse that clears every active state
always @(posedge clk_i) begin
	if (rst_i)
		clear_active_o <= 1'b0;
	else
		clear_active_o <= rctl_wr &
			wr_one(wb_sel_i, wb_dat_i, `SEC_RCTL_CLR_ACT);
end

////////////////////////////////////////////////////////////////////////////////
// Priority mask and fault escalation

always @(posedge clk_i) begin
	if (rst_i)
		priority_mask_o <= `SEC_CTRL_RST;
	else if (pmask_wr & lane_on(wb_sel_i, `SEC_PMASK_BIT))
		priority_mask_o <= wb_dat_i[`SEC_PMASK_BIT];
end

always @(posedge clk_i) begin
	if (rst_i) begin
		escalate_hardfault_o <= 1'b0;
		fault_taken_o <= 1'b0;
	end else begin
		escalate_hardfault_o <= fault_i & priority_mask_o;
		fault_taken_o <= fault_i & ~priority_mask_o;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read data

reg [31:0] rd_data;

always @* begin
	rd_data = `SEC_DATA_RST;
	if (hit_ctst) begin
		rd_data[`SEC_CTST_NMI_SET] = nmi_pend_o;
		rd_data[`SEC_CTST_SVC_SET] = svc_pend_o;
		rd_data[`SEC_CTST_TICK_SET] = tick_pend_o;
		rd_data[`SEC_CTST_TICK_NS] = tick_nonsecure_o;
		rd_data[`SEC_CTST_STEP_PRE] = step_preempt_i;
		rd_data[`SEC_CTST_IRQ_PEND] = irq_pending_i;
		rd_data[`SEC_CTST_PEND_MSB:`SEC_CTST_PEND_LSB] =
			pending_num_i;
		rd_data[`SEC_CTST_RET_BASE] = ret_base_r;
		rd_data[`SEC_CTST_ACT_MSB:`SEC_CTST_ACT_LSB] =
			active_num_i;
	end else if (hit_rctl) begin
		rd_data[`SEC_RCTL_ENDIAN] = endian_r;
		rd_data[`SEC_RCTL_SBOOST] = secure_priority_boost_o;
		rd_data[`SEC_RCTL_FLT_NS] = fault_nmi_security_o;
		rd_data[`SEC_RCTL_GRP_MSB:`SEC_RCTL_GRP_LSB] = priority_group_o;
		rd_data[`SEC_RCTL_RST_SEC] = rst_sec_only_r;
	end else if (hit_pmask) begin
		rd_data[`SEC_PMASK_BIT] = priority_mask_o;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Bus answer, one wait state, unmapped reads return zero

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= `SEC_DATA_RST;
	end else begin
		wb_ack_o <= req;
		if (rd_acc)
			wb_dat_o <= rd_data;
		else
			wb_dat_o <= `SEC_DATA_RST;
	end
end

endmodule // sec_exc_ctrl

`default_nettype wire

// file: sec_exc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sec_exc_ctrl_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic bus_priv_i,
	input wire logic fault_i,
	input wire logic nmi_pend_o,
	input wire logic [2:0] priority_group_o,
	input wire logic reset_request_o,
	input wire logic clear_active_o,
	input wire logic priority_mask_o,
	input wire logic escalate_hardfault_o,
	input wire logic fault_taken_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = tk & wb_we_i;
	wire [7:0] a = wb_adr_i & 8'hfc;
	wire ks = wb_dat_i[31:16] == 16'h05fa && wb_sel_i == 4'hf;
	////////////////////////////////////////////////////////////////////////
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_ack_answer: assert property (tk |=> wb_ack_o)
		else $error("no ack");
	a_nmi_set: assert property (
		wr && a == 8'h04 && wb_sel_i[3] && wb_dat_i[31] |=> nmi_pend_o)
		else $error("nmi not pended");
	a_nmi_clear: assert property (
		wr && a == 8'h04 && wb_sel_i[3] && wb_dat_i[30] && !wb_dat_i[31]
		|=> !nmi_pend_o) else $error("nmi not cleared");
	a_bad_key: assert property (
		wr && a == 8'h0c && wb_dat_i[31:16] != 16'h05fa
		|=> $stable(priority_group_o)) else $error("bad key took");
	a_clear_pulse: assert property (
		wr && a == 8'h0c && ks && wb_dat_i[1]
		|=> clear_active_o ##1 !clear_active_o) else $error("clear pulse");
	a_reset_hold: assert property (
		reset_request_o |=> reset_request_o) else $error("reset req dropped");
	a_mask_guard: assert property (
		wr && a == 8'h10 && !bus_priv_i |=> $stable(priority_mask_o))
		else $error("unprivileged mask write");
	a_fault_escalate: assert property (
		fault_i && priority_mask_o |=> escalate_hardfault_o && !fault_taken_o)
		else $error("no escalation");
	a_fault_normal: assert property (
		fault_i && !priority_mask_o |=> fault_taken_o && !escalate_hardfault_o)
		else $error("wrong fault path");
	c_key_write: cover property (wr && a == 8'h0c && ks);
	c_escalate: cover property (escalate_hardfault_o);
	c_reset_req: cover property (reset_request_o);
endmodule // sec_exc_ctrl_monitor
`default_nettype wire

// file: sec_exc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module sec_exc_ctrl_test;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic bus_priv_i = 0, bus_secure_i = 0, dbg_reset_req_i = 0;
	logic tick_event_i = 0, nmi_taken_i = 0, svc_taken_i = 0;
	logic tick_taken_i = 0, irq_pending_i = 0, step_preempt_i = 0;
	logic exc_return_i = 0, fault_i = 0, big_endian_i = 1;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, rd;
	logic [8:0] pending_num_i = 0, active_num_i = 0;
	wire [31:0] wb_dat_o;
	wire [2:0] priority_group_o;
	wire wb_ack_o, nmi_pend_o, svc_pend_o, tick_pend_o, tick_nonsecure_o;
	wire secure_priority_boost_o, fault_nmi_security_o, reset_request_o;
	wire clear_active_o, priority_mask_o, return_to_thread_o;
	wire escalate_hardfault_o, fault_taken_o;
	integer bad_count = 0, tests_run = 0, i;
	int sb[3] = '{31, 28, 26};
	int cb[3] = '{30, 27, 25};
	sec_exc_ctrl dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.bus_priv_i(bus_priv_i),
		.bus_secure_i(bus_secure_i),
		.dbg_reset_req_i(dbg_reset_req_i),
		.tick_event_i(tick_event_i),
		.nmi_taken_i(nmi_taken_i),
		.svc_taken_i(svc_taken_i),
		.tick_taken_i(tick_taken_i),
		.irq_pending_i(irq_pending_i),
		.pending_num_i(pending_num_i),
		.active_num_i(active_num_i),
		.step_preempt_i(step_preempt_i),
		.exc_return_i(exc_return_i),
		.fault_i(fault_i),
		.big_endian_i(big_endian_i),
		.nmi_pend_o(nmi_pend_o),
		.svc_pend_o(svc_pend_o),
		.tick_pend_o(tick_pend_o),
		.tick_nonsecure_o(tick_nonsecure_o),
		.secure_priority_boost_o(secure_priority_boost_o),
		.fault_nmi_security_o(fault_nmi_security_o),
		.priority_group_o(priority_group_o),
		.reset_request_o(reset_request_o),
		.clear_active_o(clear_active_o),
		.priority_mask_o(priority_mask_o),
		.return_to_thread_o(return_to_thread_o),
		.escalate_hardfault_o(escalate_hardfault_o),
		.fault_taken_o(fault_taken_o)
	);
	always #2 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		begin
			$display("Checks %0d, mismatches %0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp, input string nm);
		begin
			tests_run++;
			if (got !== exp) begin
				bad_count++;
				$display("BAD %s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task bus(input [7:0] a, input w, input [31:0] d, input [3:0] s);
		integer n;
		begin
			wb_cyc_i <= 1;
			wb_stb_i <= 1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_sel_i <= s;
			wb_dat_i <= d;
			n = 0;
			do begin
				@(posedge clk_i);
				n++;
			end while (wb_ack_o !== 1'b1 && n < 20);
			if (n >= 20) begin
				bad_count++;
				tally_and_finish;
			end
			rd = wb_dat_o;
			wb_cyc_i <= 0;
			wb_stb_i <= 0;
			wb_we_i <= 0;
			@(posedge clk_i);
		end
	endtask
	task rdc(input [7:0] a, input [31:0] exp, input string nm);
		begin
			bus(a, 0, 32'h0, 4'hf);
			chk(rd, exp, nm);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		repeat (4) @(posedge clk_i);
		for (i = 0; i < 3; i++) begin
			bus(8'h04, 1, 32'h1 << sb[i], 4'hf);
			rdc(8'h04, 32'h1 << sb[i], "pend set");
			chk({nmi_pend_o, svc_pend_o, tick_pend_o}, 32'h4 >> i, "flags");
			bus(8'h04, 1, 32'h0, 4'hf);
			rdc(8'h04, 32'h1 << sb[i], "pend zero");
			bus(8'h04, 1, 32'h1 << cb[i], 4'hf);
			rdc(8'h04, 32'h0, "pend clear");
		end
		tick_event_i <= 1;
		@(posedge clk_i);
		tick_event_i <= 0;
		tick_taken_i <= 1;
		@(posedge clk_i);
		chk(tick_pend_o, 1, "tick event");
		tick_taken_i <= 0;
		@(posedge clk_i);
		chk(tick_pend_o, 0, "tick taken");
		irq_pending_i <= 1;
		step_preempt_i <= 1;
		pending_num_i <= 9'h1a5;
		active_num_i <= 9'h0f3;
		@(posedge clk_i);
		rdc(8'h04, 32'h00da50f3, "live");
		irq_pending_i <= 0;
		step_preempt_i <= 0;
		pending_num_i <= 0;
		repeat (2) @(posedge clk_i);
		rdc(8'h04, 32'h000008f3, "base");
		exc_return_i <= 1;
		@(posedge clk_i);
		exc_return_i <= 0;
		active_num_i <= 0;
		@(posedge clk_i);
		chk(return_to_thread_o, 1, "to thread");
		bus(8'h04, 1, 32'h01000000, 4'hf);
		rdc(8'h04, 32'h01000000, "tick ns");
		chk(tick_nonsecure_o, 1, "tick ns out");
		rdc(8'h0c, 32'h00008000, "endian");
		bus(8'h0c, 1, 32'h12346700, 4'hf);
		rdc(8'h0c, 32'h00008000, "bad key");
		bus(8'h0c, 1, 32'h05fa6700, 4'hf);
		rdc(8'h0c, 32'h0000e700, "good key");
		chk({priority_group_o, secure_priority_boost_o, fault_nmi_security_o},
			32'h1f, "ctl outs");
		bus(8'h0c, 1, 32'h05fa0002, 4'hf);
		rdc(8'h0c, 32'h00008000, "clr act");
		bus(8'h0c, 1, 32'h05fa0008, 4'hf);
		rdc(8'h0c, 32'h00008000, "ns bit3");
		bus_secure_i <= 1;
		bus(8'h0c, 1, 32'h05fa0008, 4'hf);
		rdc(8'h0c, 32'h00008008, "s bit3");
		bus_secure_i <= 0;
		bus(8'h0c, 1, 32'h05fa000c, 4'hf);
		chk(reset_request_o, 0, "ns rst req");
		bus_secure_i <= 1;
		bus(8'h0c, 1, 32'h05fa000c, 4'hf);
		chk(reset_request_o, 1, "s rst req");
		bus(8'h10, 1, 32'h1, 4'hf);
		rdc(8'h10, 32'h0, "unpriv mask");
		bus_priv_i <= 1;
		bus(8'h10, 1, 32'h1, 4'hf);
		rdc(8'h10, 32'h1, "priv mask");
		fault_i <= 1;
		@(posedge clk_i);
		fault_i <= 0;
		@(posedge clk_i);
		chk(escalate_hardfault_o, 1, "escalate");
		bus(8'h10, 1, 32'h0, 4'hf);
		fault_i <= 1;
		@(posedge clk_i);
		fault_i <= 0;
		@(posedge clk_i);
		chk(fault_taken_o, 1, "fault taken");
		rdc(8'h08, 32'h0, "unmapped");
		rst_i <= 1;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(reset_request_o, 0, "rst req reset");
		tally_and_finish;
	end
endmodule // sec_exc_ctrl_test
bind sec_exc_ctrl sec_exc_ctrl_monitor mon (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o),
	.bus_priv_i(bus_priv_i),
	.fault_i(fault_i),
	.nmi_pend_o(nmi_pend_o),
	.priority_group_o(priority_group_o),
	.reset_request_o(reset_request_o),
	.clear_active_o(clear_active_o),
	.priority_mask_o(priority_mask_o),
	.escalate_hardfault_o(escalate_hardfault_o),
	.fault_taken_o(fault_taken_o)
);
`default_nettype wire

// file: sec_regs.vh
`ifndef SEC_REGS_VH
`define SEC_REGS_VH

// Register offsets, byte addresses
`define SEC_OFF_CTST 8'h04
`define SEC_OFF_RCTL 8'h0c
`define SEC_OFF_PMASK 8'h10

// Control-and-state register fields
`define SEC_CTST_NMI_SET 31
`define SEC_CTST_NMI_CLR 30
`define SEC_CTST_SVC_SET 28
`define SEC_CTST_SVC_CLR 27
`define SEC_CTST_TICK_SET 26
`define SEC_CTST_TICK_CLR 25
`define SEC_CTST_TICK_NS 24
`define SEC_CTST_STEP_PRE 23
`define SEC_CTST_IRQ_PEND 22
`define SEC_CTST_PEND_MSB 20
`define SEC_CTST_PEND_LSB 12
`define SEC_CTST_RET_BASE 11
`define SEC_CTST_ACT_MSB 8
`define SEC_CTST_ACT_LSB 0

// Reset-control register fields
`define SEC_RCTL_KEY_MSB 31
`define SEC_RCTL_KEY_LSB 16
`define SEC_RCTL_KEY 16'h05fa
`define SEC_RCTL_ENDIAN 15
`define SEC_RCTL_SBOOST 14
`define SEC_RCTL_FLT_NS 13
`define SEC_RCTL_GRP_MSB 10
`define SEC_RCTL_GRP_LSB 8
`define SEC_RCTL_RST_SEC 3
`define SEC_RCTL_RST_REQ 2
`define SEC_RCTL_CLR_ACT 1

// Priority mask register field
`define SEC_PMASK_BIT 0

// Reset values
`define SEC_PEND_RST 1'b0
`define SEC_CTRL_RST 1'b0
`define SEC_GRP_RST 3'h0
`define SEC_DATA_RST 32'h00000000

// Cycles after reset release before the endianness strap is caught
`define SEC_STRAP_WAIT 2'h2

`endif
